// ---- verilog/scc_pkg.sv ----
// package of constants and types for the system clock source control block
package scc_pkg;

  // register byte offsets
  localparam logic [7:0] CLOCK_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] CLOCK_CONFIG_REG_OFS = 8'h08;
  localparam logic [7:0] CONTROL_STATUS_REG_OFS = 8'h34;

  // clock_control_reg field positions
  localparam int FAST_INTERNAL_ENABLE_BIT = 0;
  localparam int FAST_INTERNAL_READY_BIT = 1;
  localparam int MULTI_RATE_OSC_ENABLE_BIT = 8;
  localparam int MULTI_RATE_OSC_READY_BIT = 9;
  localparam int FAST_EXTERNAL_ENABLE_BIT = 16;
  localparam int FAST_EXTERNAL_READY_BIT = 17;
  localparam int PLL_ENABLE_BIT = 24;
  localparam int PLL_READY_BIT = 25;

  // clock_config_reg field positions
  localparam int SYSCLK_SELECT_LSB = 0;
  localparam int SYSCLK_SELECT_STATUS_LSB = 2;
  localparam int PLL_SOURCE_BIT = 16;
  localparam int PLL_MULT_LSB = 18;
  localparam int PLL_OUTPUT_DIVIDER_LSB = 22;
  localparam int MULTI_RATE_RANGE_LSB = 28;

  // control_status_reg field positions
  localparam int SLOW_INTERNAL_ENABLE_BIT = 0;
  localparam int SLOW_INTERNAL_READY_BIT = 1;
  localparam int SLOW_EXTERNAL_ENABLE_BIT = 8;
  localparam int SLOW_EXTERNAL_READY_BIT = 9;

  // oscillator and pll stabilisation times, in ns, and cycle counts at 100 MHz
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FAST_OSC_START_NS = 2000;
  localparam int SLOW_OSC_START_NS = 20000;
  localparam int FAST_OSC_START_CYC = (FAST_OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLOW_OSC_START_CYC = (SLOW_OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // system clock source codes
  typedef enum logic [1:0] {
    SRC_MULTI_RATE = 2'h0,
    SRC_FAST_INTERNAL = 2'h1,
    SRC_FAST_EXTERNAL = 2'h2,
    SRC_PLL = 2'h3
  } scc_src_type;

  // multi-rate oscillator ranges, 64 kHz up to 4.1 MHz
  typedef enum logic [2:0] {
    RANGE_64K = 3'h0,
    RANGE_128K = 3'h1,
    RANGE_256K = 3'h2,
    RANGE_512K = 3'h3,
    RANGE_1M02 = 3'h4,
    RANGE_2M05 = 3'h5,
    RANGE_4M1 = 3'h6
  } scc_range_type;

  // configuration register contents
  typedef struct packed {
    logic [2:0] msi_range;
    logic [1:0] pll_div;
    logic [3:0] pll_mult;
    logic pll_src_ext;
    scc_src_type sysclk_select;
  } scc_cfg_type;

  // reset values
  localparam logic [3:0] PLL_MULT_RST = 4'h0;
  localparam logic [1:0] PLL_DIV_RST = 2'h1;
  localparam scc_cfg_type CFG_RST = '{RANGE_2M05, PLL_DIV_RST, PLL_MULT_RST, 1'b0, SRC_MULTI_RATE};

  // oscillator indices for the ready generator
  localparam int OSC_COUNT = 6;
  localparam int OSC_MSI = 0;
  localparam int OSC_HSI = 1;
  localparam int OSC_HSE = 2;
  localparam int OSC_PLL = 3;
  localparam int OSC_LSI = 4;
  localparam int OSC_LSE = 5;

endpackage

// ---- verilog/scc_osc_ready.sv ----
`timescale 1ns/100ps
// stabilisation counter that raises a ready flag after an enable
module scc_osc_ready
  import scc_pkg::*;
#(
  parameter int START_CYC = FAST_OSC_START_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic enable,
  input wire logic reset_ready,
  // status
  output logic ready
);

  localparam int CW = $clog2(START_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(START_CYC - 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ready_q;
  logic ready_d;
  wire done = (count_q == LAST);

  assign count_d = (!enable || reset_ready) ? '0 : (done ? count_q : count_q + CW'(1));
  assign ready_d = enable && !reset_ready && (ready_q || done);
  assign ready = ready_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= ready_d;
    end
  end

endmodule

// ---- verilog/scc_top.sv ----
`timescale 1ns/100ps
// system clock source control with ahb-lite register slave
//
// Summary of operation
// (RL1) multi-rate oscillator offers seven frequency ranges
// (RL2) system clock from exactly one of four
// (RL3) select field written; status field reports source
// (RL4) reset runs multi-rate oscillator at 2 MHz
// (RL5) pll enable bit and ready flag
// (RL6) pll reference only fast internal or external
// (RL7) pll output divider and multiplier fields
// (RL8) slow external bits in control/status register
// (RL9) slow external enable/ready at bits 9:8
// (RL10) software sets flash wait states per frequency
// (RL11) each oscillator enable plus stable ready flag
// (RL12) switch only to ready source, then status
module scc_top
  import scc_pkg::*;
(
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock tree controls
  output logic [5:0] osc_enable,
  output scc_src_type sysclk_mux,
  output scc_cfg_type pll_msi_cfg
);

  // bus address phase capture
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_cr = wr_q && addr_q == CLOCK_CONTROL_REG_OFS;
  wire wr_cfg = wr_q && addr_q == CLOCK_CONFIG_REG_OFS;
  wire wr_csr = wr_q && addr_q == CONTROL_STATUS_REG_OFS;

  // control registers
  logic [5:0] en_q;
  logic [5:0] en_d;
  scc_cfg_type cfg_q;
  scc_cfg_type cfg_d;
  scc_src_type sws_q;
  scc_src_type sws_d;
  logic [5:0] rdy;
  logic [5:0] rdy_q;
  typedef enum logic {SW_STEADY, SW_HANDOVER} scc_switch_type;
  scc_switch_type sw_q;
  scc_switch_type sw_d;
  scc_src_type tgt_q;
  scc_src_type tgt_d;
  logic hreadyout_q;
  logic hresp_q;

  // enables from written bits; the running source cannot be switched off
  wire [5:0] en_wr = {hwdata[SLOW_EXTERNAL_ENABLE_BIT], hwdata[SLOW_INTERNAL_ENABLE_BIT], hwdata[PLL_ENABLE_BIT],
    hwdata[FAST_EXTERNAL_ENABLE_BIT], hwdata[FAST_INTERNAL_ENABLE_BIT], hwdata[MULTI_RATE_OSC_ENABLE_BIT]};
  wire [5:0] cr_mask = 6'h0F;
  wire [5:0] csr_mask = 6'h30;
  wire [5:0] en_cr = (en_q & ~cr_mask) | (en_wr & cr_mask); // RL5
  wire [5:0] en_csr = (en_q & ~csr_mask) | (en_wr & csr_mask); // RL8
  wire [5:0] en_pre = wr_cr ? en_cr : (wr_csr ? en_csr : en_q);
  // source in use next cycle and the handover target both stay on
  wire [3:0] run_src = (4'h1 << sws_d) | ((sw_d == SW_HANDOVER) ? (4'h1 << tgt_d) : 4'h0);
  wire [5:0] en_keep = en_pre | {2'b00, run_src};
  // reference of an enabled pll must be kept on as well
  wire [5:0] pll_ref_keep = en_keep[OSC_PLL] ? (cfg_q.pll_src_ext ? 6'h04 : 6'h02) : 6'h00; // RL6
  assign en_d = en_keep | pll_ref_keep; // RL11

  // configuration write; pll fields frozen while the pll is on
  wire pll_lock = en_q[OSC_PLL];
  wire [2:0] range_wr = hwdata[MULTI_RATE_RANGE_LSB +: 3];
  wire range_ok = range_wr != 3'h7; // RL1
  scc_cfg_type cfg_wr;
  assign cfg_wr.sysclk_select = scc_src_type'(hwdata[SYSCLK_SELECT_LSB +: 2]); // RL3
  assign cfg_wr.pll_src_ext = pll_lock ? cfg_q.pll_src_ext : hwdata[PLL_SOURCE_BIT]; // RL6
  assign cfg_wr.pll_mult = pll_lock ? cfg_q.pll_mult : hwdata[PLL_MULT_LSB +: 4]; // RL7
  assign cfg_wr.pll_div = pll_lock ? cfg_q.pll_div : hwdata[PLL_OUTPUT_DIVIDER_LSB +: 2]; // RL7
  assign cfg_wr.msi_range = range_ok ? range_wr : cfg_q.msi_range; // RL1
  assign cfg_d = wr_cfg ? cfg_wr : cfg_q;

  // switch only to an enabled, ready target; old and new source both run during the handover
  wire [3:0] src_rdy = rdy_q[3:0] & en_q[3:0];
  wire tgt_rdy = src_rdy[cfg_q.sysclk_select];
  wire sw_start = cfg_q.sysclk_select != sws_q && tgt_rdy;
  wire sw_keep = cfg_q.sysclk_select == tgt_q && tgt_rdy;

  always_comb begin
    sw_d = sw_q;
    tgt_d = tgt_q;
    sws_d = sws_q;
    unique case (sw_q)
      SW_STEADY: begin
        if (sw_start) begin
          sw_d = SW_HANDOVER;
          tgt_d = cfg_q.sysclk_select;
        end
      end
      SW_HANDOVER: begin
        sw_d = SW_STEADY;
        if (sw_keep) begin
          sws_d = tgt_q; // RL12 RL2
        end
      end
    endcase
  end

  // ready generators, one per oscillator
  genvar g;
  generate
    for (g = 0; g < OSC_COUNT; g++) begin : gen_osc
      localparam int CYC = (g >= OSC_LSI) ? SLOW_OSC_START_CYC : FAST_OSC_START_CYC;
      wire ref_lost = (g == OSC_PLL) && !rdy_q[cfg_q.pll_src_ext ? OSC_HSE : OSC_HSI];
      wire retune = (g == OSC_MSI) && wr_cfg && range_ok && range_wr != cfg_q.msi_range;
      scc_osc_ready #(
        .START_CYC(CYC)
      ) u_rdy (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(en_q[g]),
        .reset_ready(ref_lost || retune),
        .ready(rdy[g])
      ); // RL11
    end
  endgenerate

  // register readback
  wire [31:0] cr_val = (32'(en_q[OSC_HSI]) << FAST_INTERNAL_ENABLE_BIT) |
    (32'(rdy_q[OSC_HSI]) << FAST_INTERNAL_READY_BIT) |
    (32'(en_q[OSC_MSI]) << MULTI_RATE_OSC_ENABLE_BIT) |
    (32'(rdy_q[OSC_MSI]) << MULTI_RATE_OSC_READY_BIT) |
    (32'(en_q[OSC_HSE]) << FAST_EXTERNAL_ENABLE_BIT) |
    (32'(rdy_q[OSC_HSE]) << FAST_EXTERNAL_READY_BIT) |
    (32'(en_q[OSC_PLL]) << PLL_ENABLE_BIT) |
    (32'(rdy_q[OSC_PLL]) << PLL_READY_BIT); // RL5
  wire [31:0] cfg_val = (32'(cfg_q.sysclk_select) << SYSCLK_SELECT_LSB) |
    (32'(sws_q) << SYSCLK_SELECT_STATUS_LSB) |
    (32'(cfg_q.pll_src_ext) << PLL_SOURCE_BIT) |
    (32'(cfg_q.pll_mult) << PLL_MULT_LSB) |
    (32'(cfg_q.pll_div) << PLL_OUTPUT_DIVIDER_LSB) |
    (32'(cfg_q.msi_range) << MULTI_RATE_RANGE_LSB); // RL3
  wire [31:0] csr_val = (32'(en_q[OSC_LSI]) << SLOW_INTERNAL_ENABLE_BIT) |
    (32'(rdy_q[OSC_LSI]) << SLOW_INTERNAL_READY_BIT) |
    (32'(en_q[OSC_LSE]) << SLOW_EXTERNAL_ENABLE_BIT) |
    (32'(rdy_q[OSC_LSE]) << SLOW_EXTERNAL_READY_BIT); // RL9
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] rd_val = (rd_addr == CLOCK_CONTROL_REG_OFS) ? cr_val :
    (rd_addr == CLOCK_CONFIG_REG_OFS) ? cfg_val :
    (rd_addr == CONTROL_STATUS_REG_OFS) ? csr_val : 32'h00000000;

  assign hrdata = rdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign osc_enable = en_q;
  assign sysclk_mux = sws_q;
  assign pll_msi_cfg = cfg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_q <= addr_phase && hwrite;
      addr_q <= haddr[7:0];
      rdata_q <= (addr_phase && !hwrite) ? rd_val : rdata_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 6'h01; // RL4
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RST; // RL4
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_q <= SW_STEADY;
      tgt_q <= SRC_MULTI_RATE;
      sws_q <= SRC_MULTI_RATE; // RL4
    end else begin
      sw_q <= sw_d;
      tgt_q <= tgt_d;
      sws_q <= sws_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= 6'h00;
    end else begin
      rdy_q <= rdy;
    end
  end

endmodule

// ---- verif/scc_properties.sv ----
// port assertions for the system clock source control block
`timescale 1ns/100ps
module scc_properties
  import scc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [5:0] osc_enable,
  input wire scc_src_type sysclk_mux,
  input wire scc_cfg_type pll_msi_cfg
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence pll_held_s;
    osc_enable[3] && $past(osc_enable[3]);
  endsequence
  sequence mux_moved_s;
    $changed(sysclk_mux);
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus wait or error seen");
  reset_src_a: assert property ($rose(hresetn) |-> osc_enable == 6'h01 && sysclk_mux == SRC_MULTI_RATE)
    else $error("wrong source after reset");
  reset_cfg_a: assert property ($rose(hresetn) |-> pll_msi_cfg == CFG_RST) else $error("wrong config after reset");
  mux_follows_a: assert property (mux_moved_s |-> $past(pll_msi_cfg[1:0]) == sysclk_mux)
    else $error("source moved without select");
  mux_enabled_a: assert property (osc_enable[sysclk_mux]) else $error("running source disabled");
  pll_cfg_hold_a: assert property (pll_held_s |-> $stable(pll_msi_cfg[8:2])) else $error("pll setup changed");
  pll_ref_on_a: assert property (osc_enable[3] |-> osc_enable[pll_msi_cfg.pll_src_ext ? 2 : 1])
    else $error("pll reference off");
  range_legal_a: assert property (pll_msi_cfg.msi_range != 3'h7) else $error("illegal range");
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the system clock source control block
`timescale 1ns/100ps
bind scc_top scc_properties scc_properties_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .osc_enable(osc_enable), .sysclk_mux(sysclk_mux), .pll_msi_cfg(pll_msi_cfg));
module tb
  import scc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] osc_enable;
  scc_src_type sysclk_mux;
  scc_cfg_type pll_msi_cfg;
  int err_count, checks, mcfg;
  scc_top scc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_enable(osc_enable), .sysclk_mux(sysclk_mux),
    .pll_msi_cfg(pll_msi_cfg));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rd2(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
    xfer(1'b0, a, 32'h0);
  endtask
  task poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 1500);
    chk("ready", 32'h1, {31'h0, rd[b]});
  endtask
  task cfgw(input logic [31:0] v, input logic [1:0] s);
    xfer(1'b1, CLOCK_CONFIG_REG_OFS, v);
    rd2(CLOCK_CONFIG_REG_OFS);
    chk("cfg", mcfg | {28'h0, s, 2'h0}, rd);
  endtask
  task test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    test_done;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    rd = $urandom(32'h09F3);
    repeat (6) @(posedge hclk);
    chk("osc", 32'h1, {26'h0, osc_enable});
    chk("cfgout", {20'h0, CFG_RST}, {20'h0, pll_msi_cfg});
    hresetn <= 1'b1;
    mcfg = 32'h5040_0000;
    cfgw(mcfg, 2'h0);
    poll(CLOCK_CONTROL_REG_OFS, MULTI_RATE_OSC_READY_BIT);
    $display("test reset done");
    mcfg = 32'h5040_0002;
    cfgw(mcfg, 2'h0);
    mcfg = 32'h5040_0001;
    cfgw(mcfg, 2'h0);
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0000_0101);
    poll(CLOCK_CONTROL_REG_OFS, FAST_INTERNAL_READY_BIT);
    cfgw(mcfg, 2'h1);
    chk("mux", 32'h1, {30'h0, sysclk_mux});
    $display("test switch done");
    mcfg = 32'h5000_0001 | ($urandom & 32'h00FC_0000);
    cfgw(mcfg, 2'h1);
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0100_0101);
    poll(CLOCK_CONTROL_REG_OFS, PLL_READY_BIT);
    mcfg = mcfg | 3;
    cfgw(mcfg, 2'h3);
    chk("mux", 32'h3, {30'h0, sysclk_mux});
    cfgw(mcfg ^ 32'h0005_0000, 2'h3);
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0100_0100);
    rd2(CLOCK_CONTROL_REG_OFS);
    chk("pllref", 32'h1, {31'h0, rd[0]});
    for (int r = 0; r < 8; r++) begin
      if (r < 7) mcfg[30:28] = r[2:0];
      cfgw({1'b0, r[2:0], mcfg[27:0]}, 2'h3);
    end
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0101_0100);
    poll(CLOCK_CONTROL_REG_OFS, FAST_EXTERNAL_READY_BIT);
    mcfg[1:0] = 2'h2;
    cfgw(mcfg, 2'h2);
    chk("mux", 32'h2, {30'h0, sysclk_mux});
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0001_0100);
    mcfg[16] = 1'b1;
    cfgw(mcfg, 2'h2);
    xfer(1'b1, CLOCK_CONTROL_REG_OFS, 32'h0100_0100);
    poll(CLOCK_CONTROL_REG_OFS, PLL_READY_BIT);
    $display("test pll done");
    xfer(1'b1, CONTROL_STATUS_REG_OFS, 32'h101);
    poll(CONTROL_STATUS_REG_OFS, SLOW_EXTERNAL_READY_BIT);
    poll(CONTROL_STATUS_REG_OFS, SLOW_INTERNAL_READY_BIT);
    chk("slowen", 32'h1, {31'h0, osc_enable[5]});
    xfer(1'b1, CONTROL_STATUS_REG_OFS, 32'h0);
    rd2(CONTROL_STATUS_REG_OFS);
    chk("slowoff", 32'h0, rd);
    xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd2(8'h10);
    chk("unmapped", 32'h0, rd);
    $display("test slow done");
    test_done;
  end
endmodule
